// ===== test_uart_flow_control_handshake.sv
// Self-checking bench for the serial handshake block
module test_uart_flow_control_handshake;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, arst_n, cfg_we, is_gateway, packet_mode, drain, pkt_last, cmd_bad, tx_busy;
    logic go, obey_cts, rts_ready, rts_n, cts_n, pkt_ready, form_packet, retry_pulse, ack_on;
    logic [7:0] cfg_wdata, margin, handshake_select, rd_data, first_tx, second_tx;
    logic [8:0] fill_level, held;
    ufch_pkg::ufch_byte_s rx_byte, pkt_byte, tx_byte;
    int failures, checks_done, cycles, tx_cnt, form_cnt, retry_cnt, i;
    logic stop_seen, dir_bad, resume_seen;

    ufch_handshake uut (.ref_clk(ref_clk), .arst_n(arst_n), .cfg_we(cfg_we), .cfg_wdata(cfg_wdata),
        .margin(margin), .is_gateway(is_gateway), .packet_mode(packet_mode), .rx_byte(rx_byte),
        .rts_n(rts_n), .drain(drain), .pkt_byte(pkt_byte), .pkt_last(pkt_last), .cmd_bad(cmd_bad),
        .tx_busy(tx_busy), .handshake_select(handshake_select), .cts_n(cts_n), .tx_byte(tx_byte),
        .pkt_ready(pkt_ready), .form_packet(form_packet), .fill_level(fill_level), .rd_data(rd_data),
        .retry_pulse(retry_pulse));

    ufch_host_model host (.ref_clk(ref_clk), .arst_n(arst_n), .go(go), .obey_cts(obey_cts),
        .rts_ready(rts_ready), .ack_on(ack_on), .cts_n(cts_n), .tx_byte(tx_byte), .rx_byte(rx_byte),
        .rts_n(rts_n));

    // Free-running 100 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Watches transmit traffic and cuts a hang short
    always @(posedge ref_clk)
    begin
        cycles++;
        if (tx_byte.valid === 1'b1)
        begin
            if (tx_cnt == 0)
                first_tx = tx_byte.data;
            if (tx_cnt == 1)
                second_tx = tx_byte.data;
            tx_cnt++;
            if (tx_byte.data === ufch_pkg::CH_STOP)
                stop_seen = 1'b1;
            if (tx_byte.data === ufch_pkg::CH_RESUME)
                resume_seen = 1'b1;
            if (handshake_select[ufch_pkg::BIT_DIR] === 1'b1 && cts_n !== 1'b0)
                dir_bad = 1'b1;
        end
        if (form_packet === 1'b1)
            form_cnt++;
        if (retry_pulse === 1'b1)
            retry_cnt++;
        if (cycles == 20000)
        begin
            failures++;
            give_verdict();
        end
    end

    task automatic check(input string name, input logic [8:0] exp, input logic [8:0] got);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic set_cfg(input logic [7:0] v);
        cfg_wdata = v;
        cfg_we = 1'b1;
        tick(1);
        cfg_we = 1'b0;
        tick(2);
    endtask

    task automatic empty_buf();
        go = 1'b0;
        tick(4);
        drain = 1'b1;
        tick(1);
        drain = 0;
        tick(4);
    endtask

    // Three packet bytes, the last one flagged
    task automatic send_pkt();
        tx_cnt = 0;
        for (i = 0; i < 3; i++)
        begin
            pkt_byte = {1'b1, 8'hA0 + 8'(i)};
            pkt_last = (i == 2);
            tick(1);
        end
        pkt_byte = '0;
        pkt_last = 1'b0;
    endtask

    task automatic t_reset_cfg();
        tick(3);
        check("select", 9'(ufch_pkg::HS_RESET), 9'(handshake_select));
        check("cts_n", 9'h000, 9'(cts_n));
        set_cfg(8'hC1);
        check("select", 9'h0C1, 9'(handshake_select));
        check("rd_data", 9'h0C1, 9'(rd_data));
        set_cfg(ufch_pkg::HS_RESET);
    endtask

    task automatic t_cts_fill();
        obey_cts = 1'b1;
        go = 1'b1;
        for (i = 0; i < 2000 && cts_n !== 1'b1; i++)
            tick(1);
        tick(10);
        check("fill in margin", 9'h001, 9'(fill_level >= ufch_pkg::BUF_FULL - {1'b0, margin}
            && fill_level < ufch_pkg::BUF_FULL));
        held = fill_level;
        obey_cts = 1'b0;
        tick(30);
        check("fill held", held, fill_level);
        empty_buf();
        check("fill empty", 9'h000, fill_level);
        check("cts_n", 9'h000, 9'(cts_n));
    endtask

    task automatic t_overflow();
        set_cfg(8'h00);
        form_cnt = 0;
        go = 1'b1;
        tick(700);
        check("fill full", ufch_pkg::BUF_FULL, fill_level);
        check("form seen", 9'h001, 9'(form_cnt > 0));
        empty_buf();
    endtask

    task automatic t_rts();
        is_gateway = 1'b1;
        set_cfg(8'h02);
        send_pkt();
        tick(50);
        check("tx while rts high", 9'h000, 9'(tx_cnt));
        tx_busy = 1'b1;
        rts_ready = 1'b1;
        tick(30);
        check("tx while busy", 9'h000, 9'(tx_cnt));
        tx_busy = 1'b0;
        tick(50);
        check("tx count", 9'h003, 9'(tx_cnt));
        check("first tx", 9'h0A0, 9'(first_tx));
    endtask

    task automatic t_dir();
        set_cfg(8'h04);
        dir_bad = 1'b0;
        send_pkt();
        tick(50);
        check("tx count", 9'h003, 9'(tx_cnt));
        check("dir low in tx", 9'h000, 9'(dir_bad));
        check("dir idle", 9'h001, 9'(cts_n));
    endtask

    task automatic t_xoff();
        is_gateway = 1'b0;
        set_cfg(8'h08);
        stop_seen = 1'b0;
        go = 1'b1;
        for (i = 0; i < 2000 && stop_seen !== 1'b1; i++)
            tick(1);
        tick(20);
        check("stop sent", 9'h001, 9'(stop_seen));
        check("not full", 9'h001, 9'(fill_level < ufch_pkg::BUF_FULL));
        resume_seen = 1'b0;
        empty_buf();
        check("resume after drain", 9'h001, 9'(resume_seen));
        is_gateway = 1'b1;
        packet_mode = 1'b1;
        stop_seen = 1'b0;
        go = 1'b1;
        tick(700);
        check("stop in packet mode", 9'h000, 9'(stop_seen));
        empty_buf();
    endtask

    // Nak reply ahead of the packet, then the host's ack ends the wait
    task automatic t_wack();
        is_gateway = 1'b1;
        packet_mode = 1'b0;
        set_cfg(8'h30);
        ack_on = 1'b1;
        cmd_bad = 1'b1;
        retry_cnt = 0;
        send_pkt();
        cmd_bad = 1'b0;
        tick(60);
        check("tx count", 9'h005, 9'(tx_cnt));
        check("reply number", 9'h0A2, 9'(first_tx));
        check("reply reason", 9'(ufch_pkg::NAK_FORMAT), 9'(second_tx));
        check("pending after ack", 9'h000, 9'(pkt_ready));
        check("resends", 9'h000, 9'(retry_cnt));
        ack_on = 1'b0;
    endtask

    task give_verdict();
        if (failures == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Main sequence: reset for 12 cycles, then each scenario
    initial
    begin
        {arst_n, cfg_we, is_gateway, packet_mode, drain, pkt_last, cmd_bad, tx_busy} = '0;
        {go, obey_cts, rts_ready, stop_seen, dir_bad, ack_on, resume_seen} = '0;
        {failures, checks_done, cycles, tx_cnt, form_cnt, retry_cnt} = '0;
        second_tx = 8'h00;
        cfg_wdata = 8'h00;
        margin = 8'h04;
        first_tx = 8'h00;
        pkt_byte = '0;
        tick(12);
        arst_n = 1'b1;
        t_reset_cfg();
        t_cts_fill();
        t_overflow();
        t_rts();
        t_dir();
        t_xoff();
        t_wack();
        give_verdict();
    end
endmodule // test_uart_flow_control_handshake

// ===== ufch_filter.sv
// Receive path gate: checks ack bytes and, with pacing on, admits data only while clear
module ufch_filter (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire ufch_pkg::ufch_byte_s rx_in,
    input wire logic cts_high,
    input wire logic pace_en,
    output ufch_pkg::ufch_byte_s data_out,
    output logic ack_seen
);
    typedef struct packed {
        ufch_pkg::ufch_byte_s d;
        logic a;
    } ufch_filt_s;
    ufch_filt_s st_ff, nxt_st;

    // Drop bytes arriving while the pacing line is high
    always_comb
    begin
        nxt_st.a = rx_in.valid && rx_in.data == ufch_pkg::CH_ACK;
        nxt_st.d.data = rx_in.data;
        nxt_st.d.valid = rx_in.valid && !(pace_en && cts_high);
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign data_out = st_ff.d;
    assign ack_seen = st_ff.a;
endmodule // ufch_filter

// ===== ufch_handshake.sv
// Overview of operation
// - Eight-bit handshake setting, bits 0 to 5 each enable one mechanism; resets to 0x01.
// - Bit 0: clear-to-send low while the input buffer can accept.
// - With pacing on, bytes arriving while clear-to-send is high are dropped.
// - Clear-to-send goes high a margin of bytes before full; default four.
// - Bit 1 on a gateway: send nothing while request-to-send is high.
// - Bit 2: clear-to-send low around each packet transmission for an RS485 driver.
// - Bit 3: send stop character 0x13 once buffer is within margin of full.
// - With software pacing and room, resend resume character every second.
// - Gateway uses software pacing only in transparent mode.
// - Bit 4 on a gateway: check each host command, answer ack or nak.
// - Reply byte one is the command number, nak byte two the reason.
// - Bit 5: gateway waits up to one second for host byte 0x06.
// - Without that byte in time, the gateway resends the same packet.
// - 256-byte input buffer; full triggers packet forming, later bytes lost.
// - Packet forming starts after input idle for 20 ms by default.
// - After buffer is sent, signal room again via clear-to-send or resume.
module ufch_handshake (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic cfg_we,
    input wire logic [7:0] cfg_wdata,
    input wire logic [7:0] margin,
    input wire logic is_gateway,
    input wire logic packet_mode,
    input wire ufch_pkg::ufch_byte_s rx_byte,
    input wire logic rts_n,
    input wire logic drain,
    input wire ufch_pkg::ufch_byte_s pkt_byte,
    input wire logic pkt_last,
    input wire logic cmd_bad,
    input wire logic tx_busy,
    output logic [7:0] handshake_select,
    output logic cts_n,
    output ufch_pkg::ufch_byte_s tx_byte,
    output logic pkt_ready,
    output logic form_packet,
    output logic [8:0] fill_level,
    output logic [7:0] rd_data,
    output logic retry_pulse
);
    typedef struct packed {
        logic [7:0] sel;
        logic [8:0] fill;
        logic [7:0] wp;
        logic [7:0] rp;
        logic cts;
        ufch_pkg::ufch_tx_e tx;
        ufch_pkg::ufch_byte_s out;
        logic stop_sent;
        logic resume_due;
        logic [7:0] cmd;
        logic [1:0] reply;
        logic form;
        logic pend;
        logic retry;
        logic [7:0] rd;
        logic [7:0] pkt_len;
        logic [7:0] pkt_idx;
    } ufch_st_s;
    ufch_st_s st_ff, nxt_st;
    logic [7:0] ibuf [0:ufch_pkg::BUF_DEPTH-1];
    logic [7:0] pbuf [0:ufch_pkg::BUF_DEPTH-1];
    ufch_pkg::ufch_byte_s rx_ok;
    logic ack_seen, resume_tick, ack_late, idle_out;
    logic sw_en, near_full, wr_buf;

    // Threshold test used by both the hardware and software pacing
    function automatic logic at_margin(input logic [8:0] fill, input logic [7:0] m);
        at_margin = ({1'b0, fill} + {2'b00, m}) >= {1'b0, ufch_pkg::BUF_FULL};
    endfunction

    ufch_filter u_filter (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .rx_in(rx_byte),
        .cts_high(st_ff.cts),
        .pace_en(st_ff.sel[ufch_pkg::BIT_CTS]),
        .data_out(rx_ok),
        .ack_seen(ack_seen)
    );
    ufch_timer #(.MS(ufch_pkg::RESUME_PERIOD_MS)) u_resume (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .load(resume_tick || !sw_en),
        .expired(resume_tick)
    );
    ufch_timer #(.MS(ufch_pkg::ACK_WAIT_MS)) u_ackwait (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .load(st_ff.tx == ufch_pkg::TX_SEND && nxt_st.tx == ufch_pkg::TX_WAIT),
        .expired(ack_late)
    );
    ufch_timer #(.MS(ufch_pkg::IDLE_TIMEOUT_MS)) u_idle (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .load(rx_ok.valid),
        .expired(idle_out)
    );

    assign sw_en = st_ff.sel[ufch_pkg::BIT_XON] && !(is_gateway && packet_mode);
    assign near_full = at_margin(st_ff.fill, margin);
    assign wr_buf = rx_ok.valid && st_ff.fill != ufch_pkg::BUF_FULL && !st_ff.form;

    // Input and packet buffers
    always_ff @(posedge ref_clk)
    begin
        if (wr_buf)
            ibuf[st_ff.wp] <= rx_ok.data;
        if (pkt_byte.valid)
            pbuf[st_ff.pkt_len] <= pkt_byte.data;
    end

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.form = 1'b0;
        nxt_st.retry = 1'b0;
        nxt_st.out.valid = 1'b0;
        // setting write; all eight bits taken
        if (cfg_we)
            nxt_st.sel = cfg_wdata;
        if (wr_buf)
        begin
            nxt_st.wp = st_ff.wp + 8'h01;
            nxt_st.fill = st_ff.fill + 9'h001;
        end
        // full forms at once; idle timeout forms
        if (!st_ff.form && st_ff.fill != 9'h000 &&
            ((wr_buf && st_ff.fill == ufch_pkg::BUF_FULL - 9'h001) || idle_out))
            nxt_st.form = 1'b1;
        if (drain)
        begin
            nxt_st.fill = 9'h000;
            nxt_st.rp = st_ff.wp;
            nxt_st.stop_sent = 1'b0;
            nxt_st.resume_due = sw_en;
        end
        if (resume_tick && sw_en && !near_full)
            nxt_st.resume_due = 1'b1;
        nxt_st.cts = near_full;
        if (st_ff.sel[ufch_pkg::BIT_DIR])
            nxt_st.cts = (st_ff.tx == ufch_pkg::TX_IDLE) && !tx_busy;
        else if (!st_ff.sel[ufch_pkg::BIT_CTS])
            nxt_st.cts = 1'b0;
        if (pkt_byte.valid && pkt_last && is_gateway && st_ff.sel[ufch_pkg::BIT_ACK])
        begin
            nxt_st.cmd = pkt_byte.data;
            nxt_st.reply = cmd_bad ? 2'h2 : 2'h1;
        end
        if (pkt_byte.valid && st_ff.tx == ufch_pkg::TX_IDLE)
            nxt_st.pkt_len = st_ff.pkt_len + 8'h01;
        nxt_st.pend = st_ff.pend || (pkt_byte.valid && pkt_last);
        unique case (st_ff.tx)
            ufch_pkg::TX_IDLE:
            begin
                if (!(is_gateway && st_ff.sel[ufch_pkg::BIT_RTS] && rts_n) && !tx_busy)
                begin
                    if (sw_en && near_full && !st_ff.stop_sent)
                    begin
                        nxt_st.out = '{1'b1, ufch_pkg::CH_STOP};
                        nxt_st.stop_sent = 1'b1;
                    end
                    else if (st_ff.resume_due && !near_full)
                    begin
                        nxt_st.out = '{1'b1, ufch_pkg::CH_RESUME};
                        nxt_st.resume_due = 1'b0;
                    end
                    else if (st_ff.reply != 2'h0)
                    begin
                        nxt_st.out = '{1'b1, (st_ff.reply == 2'h3) ? ufch_pkg::NAK_FORMAT : st_ff.cmd};
                        nxt_st.reply = (st_ff.reply == 2'h2) ? 2'h3 : 2'h0;
                    end
                    else if (st_ff.pend)
                    begin
                        nxt_st.pkt_idx = 8'h00;
                        nxt_st.tx = st_ff.sel[ufch_pkg::BIT_DIR] ? ufch_pkg::TX_DIR : ufch_pkg::TX_SEND;
                    end
                end
            end
            ufch_pkg::TX_DIR:
                nxt_st.tx = ufch_pkg::TX_SEND;
            ufch_pkg::TX_SEND:
            begin
                if (!tx_busy && !st_ff.out.valid &&
                    !(is_gateway && st_ff.sel[ufch_pkg::BIT_RTS] && rts_n))
                begin
                    nxt_st.out = '{1'b1, pbuf[st_ff.pkt_idx]};
                    nxt_st.pkt_idx = st_ff.pkt_idx + 8'h01;
                    if (st_ff.pkt_idx + 8'h01 == st_ff.pkt_len)
                        nxt_st.tx = (is_gateway && st_ff.sel[ufch_pkg::BIT_WACK]) ?
                            ufch_pkg::TX_WAIT : ufch_pkg::TX_IDLE;
                end
                if (nxt_st.tx == ufch_pkg::TX_IDLE)
                begin
                    nxt_st.pend = 1'b0;
                    nxt_st.pkt_len = 8'h00;
                end
            end
            ufch_pkg::TX_WAIT:
            begin
                if (ack_seen)
                begin
                    nxt_st.tx = ufch_pkg::TX_IDLE;
                    nxt_st.pend = 1'b0;
                    nxt_st.pkt_len = 8'h00;
                end
                else if (ack_late)
                begin
                    nxt_st.tx = ufch_pkg::TX_IDLE;
                    nxt_st.retry = 1'b1;
                end
            end
            default:
                nxt_st.tx = ufch_pkg::TX_IDLE;
        endcase
        nxt_st.rd = st_ff.sel;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_ff <= '0;
            st_ff.sel <= ufch_pkg::HS_RESET;
            st_ff.cts <= 1'b1;
            st_ff.tx <= ufch_pkg::TX_IDLE;
            st_ff.rd <= ufch_pkg::HS_RESET;
        end
        else
            st_ff <= nxt_st;
    end

    // Drivers straight from state flops
    assign handshake_select = st_ff.sel;
    assign cts_n = st_ff.cts;
    assign tx_byte = st_ff.out;
    assign pkt_ready = st_ff.pend;
    assign form_packet = st_ff.form;
    assign fill_level = st_ff.fill;
    assign rd_data = st_ff.rd;
    assign retry_pulse = st_ff.retry;

    property p_cts_margin;
        @(posedge ref_clk) disable iff (!arst_n)
        (st_ff.sel[1:0] == 2'b01 && st_ff.sel[ufch_pkg::BIT_DIR] == 1'b0 && near_full) |=> cts_n;
    endproperty
    a_cts_margin: assert property (p_cts_margin) else $error("cts not high near full");

    property p_drop;
        @(posedge ref_clk) disable iff (!arst_n)
        (rx_byte.valid && st_ff.cts && st_ff.sel[0]) |=> !rx_ok.valid;
    endproperty
    a_drop: assert property (p_drop) else $error("byte accepted while cts high");

    property p_stop_char;
        @(posedge ref_clk) disable iff (!arst_n)
        (tx_byte.valid && tx_byte.data == ufch_pkg::CH_STOP) |-> $past(sw_en);
    endproperty
    a_stop_char: assert property (p_stop_char) else $error("stop sent without software pacing");

    property p_rts_hold;
        @(posedge ref_clk) disable iff (!arst_n)
        (is_gateway && st_ff.sel[ufch_pkg::BIT_RTS] && rts_n) |=> !tx_byte.valid;
    endproperty
    a_rts_hold: assert property (p_rts_hold) else $error("sent while rts high");

    property p_reset_sel;
        @(posedge ref_clk) $rose(arst_n) |-> handshake_select == ufch_pkg::HS_RESET || $past(cfg_we);
    endproperty
    a_reset_sel: assert property (p_reset_sel) else $error("setting not default after reset");

    property p_retry;
        @(posedge ref_clk) disable iff (!arst_n)
        (st_ff.tx == ufch_pkg::TX_WAIT && ack_late && !ack_seen) |=> retry_pulse && pkt_ready;
    endproperty
    a_retry: assert property (p_retry) else $error("no resend after ack timeout");

    property p_full_loss;
        @(posedge ref_clk) disable iff (!arst_n)
        (st_ff.fill == ufch_pkg::BUF_FULL && !drain) |=> fill_level == ufch_pkg::BUF_FULL;
    endproperty
    a_full_loss: assert property (p_full_loss) else $error("fill moved past full");

    property p_dir;
        @(posedge ref_clk) disable iff (!arst_n)
        (st_ff.sel[2] && st_ff.tx == ufch_pkg::TX_SEND) |=> !cts_n;
    endproperty
    a_dir: assert property (p_dir) else $error("direction not low while sending");
endmodule // ufch_handshake

// ===== ufch_host_model.sv
// Host microcontroller on the far side of the serial port
module ufch_host_model (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic go,
    input wire logic obey_cts,
    input wire logic rts_ready,
    input wire logic ack_on,
    input wire logic cts_n,
    input wire ufch_pkg::ufch_byte_s tx_byte,
    output ufch_pkg::ufch_byte_s rx_byte,
    output logic rts_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic xoff_ff;
    logic gap_ff;
    logic [6:0] cnt_ff;
    logic owe_ff;
    logic [2:0] quiet_ff;

    assign rts_n = !rts_ready;

    // One byte every other cycle; idle data toggles so no stale value lingers
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            xoff_ff <= 1'b0;
            gap_ff <= 1'b0;
            cnt_ff <= 7'h00;
            owe_ff <= 1'b0;
            quiet_ff <= 3'h0;
            rx_byte <= '0;
        end
        else
        begin
            rx_byte <= {1'b0, ~rx_byte.data};
            gap_ff <= !gap_ff;
            if (tx_byte.valid && tx_byte.data == ufch_pkg::CH_STOP)
                xoff_ff <= 1'b1;
            else if ((tx_byte.valid && tx_byte.data == ufch_pkg::CH_RESUME) || !go)
                xoff_ff <= 1'b0;
            if (go && gap_ff && !xoff_ff && !(obey_cts && cts_n))
            begin
                rx_byte <= {1'b1, 1'b1, cnt_ff};
                cnt_ff <= cnt_ff + 7'h01;
            end
            // answer a delivered packet once the line has gone quiet
            if (tx_byte.valid)
            begin
                owe_ff <= ack_on;
                quiet_ff <= 3'h0;
            end
            else if (owe_ff)
            begin
                quiet_ff <= quiet_ff + 3'h1;
                if (quiet_ff == 3'h3)
                begin
                    owe_ff <= 1'b0;
                    rx_byte <= {1'b1, ufch_pkg::CH_ACK};
                end
            end
        end
    end
endmodule // ufch_host_model

// ===== ufch_pkg.sv
package ufch_pkg;
    localparam int CLK_HZ = 100000000;
    localparam logic [7:0] HS_RESET = 8'h01;
    localparam int BIT_CTS = 0;
    localparam int BIT_RTS = 1;
    localparam int BIT_DIR = 2;
    localparam int BIT_XON = 3;
    localparam int BIT_ACK = 4;
    localparam int BIT_WACK = 5;
    localparam int BUF_DEPTH = 256;
    localparam logic [8:0] BUF_FULL = 9'h100;
    localparam logic [7:0] MARGIN_RESET = 8'h04;
    localparam logic [7:0] CH_STOP = 8'h13;
    localparam logic [7:0] CH_RESUME = 8'h11;
    localparam logic [7:0] CH_ACK = 8'h06;
    localparam int RESUME_PERIOD_MS = 1000;
    localparam int ACK_WAIT_MS = 1000;
    localparam int IDLE_TIMEOUT_MS = 20;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam logic [7:0] NAK_FORMAT = 8'h01;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } ufch_byte_s;

    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_DIR = 4'h2,
        TX_SEND = 4'h4,
        TX_WAIT = 4'h8
    } ufch_tx_e;
endpackage

// ===== ufch_timer.sv
// Millisecond-scaled countdown; expires once after load, then stops
module ufch_timer #(
    parameter int MS = 1000
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic load,
    output logic expired
);
    localparam int CYC = MS * ufch_pkg::CYC_PER_MS;
    typedef struct packed {
        logic [27:0] cnt;
        logic run;
        logic exp;
    } ufch_tmr_s;
    ufch_tmr_s st_ff, nxt_st;

    // Count down from the load point to one expiry pulse
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.exp = 1'b0;
        if (load)
        begin
            nxt_st.cnt = 28'(CYC - 1);
            nxt_st.run = 1'b1;
        end
        else if (st_ff.run)
        begin
            if (st_ff.cnt == 28'h0000000)
            begin
                nxt_st.run = 1'b0;
                nxt_st.exp = 1'b1;
            end
            else
                nxt_st.cnt = st_ff.cnt - 28'h0000001;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign expired = st_ff.exp;
endmodule // ufch_timer
